//--- common/pwo_map.svh
`ifndef PWO_MAP_SVH
`define PWO_MAP_SVH

// register byte offsets on the axi4-lite slave
`define PWO_OFS_CTRL 8'h00
`define PWO_OFS_PERIOD 8'h04
`define PWO_OFS_DUTY0 8'h08
`define PWO_OFS_DUTY1 8'h0c
`define PWO_OFS_DUTY2 8'h10
`define PWO_OFS_OVSEL 8'h14
`define PWO_OFS_OVSTATE 8'h18
`define PWO_OFS_DEAD 8'h1c
`define PWO_OFS_STATUS 8'h20

// control register field positions
`define PWO_CTRL_TB_EN 0
`define PWO_CTRL_MODE_LO 1
`define PWO_CTRL_OVERRIDE_SYNC_BIT 3
`define PWO_CTRL_PMOD_LO 4
`define PWO_CTRL_IRQ_EN 7
`define PWO_CTRL_PEN_LO 8

// status register field positions
`define PWO_STAT_DIR 16
`define PWO_STAT_DONE 17

// reset values
`define PWO_RST_OVSEL 6'h3f
`define PWO_RST_OVSTATE 6'h00
`define PWO_RST_PERIOD 16'h00ff
`define PWO_RST_DUTY 16'h0000
`define PWO_RST_DEAD 6'h00
`define PWO_RST_PEN_STRAP 3'h4
`define PWO_RST_STRAP 3'h7

// axi responses
`define PWO_RESP_OKAY 2'h0
`define PWO_RESP_SLVERR 2'h2

`endif

//--- common/pwo_pkg.sv
package pwo_pkg;

   typedef logic [15:0] pwo_cnt_t;

   // time base modes, in field order: free edge, single pulse, up/down, up/down double
   typedef enum logic [1:0] {
      PWO_MODE_FREE_EDGE,
      PWO_MODE_SINGLE,
      PWO_MODE_CENTER,
      PWO_MODE_CENTER_DBL
   } pwo_mode_e;

   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic rready;
   } pwo_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pwo_axi_rsp_s;

endpackage

//--- src/pwo_core.sv
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pwo_map.svh"

module pwo_core (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire pwo_pkg::pwo_axi_req_s axi_req_in,
   output pwo_pkg::pwo_axi_rsp_s axi_rsp_out,
   input wire logic high_side_polarity_in,
   input wire logic low_side_polarity_in,
   input wire logic pin_reset_select_in,
   output logic [5:0] pwm_pin_out,
   output logic [5:0] pwm_pin_oe_n_out,
   output logic period_irq_out
);
   import pwo_pkg::*;

   // straps: {pin_reset_select, low polarity, high polarity}
   logic [2:0] strap_s1_reg, strap_s2_reg, strap_s3_reg, strap_reg;
   logic [1:0] strap_cnt_reg;
   logic cfg_done_reg;
   // control fields
   logic tb_en_reg, tb_en_d_reg, override_sync_bit_reg, irq_en_reg;
   pwo_mode_e mode_reg;
   logic [2:0] pmod_reg, pen_reg;
   pwo_cnt_t period_reg, count_reg;
   pwo_cnt_t duty_reg [3];
   logic [5:0] dead_reg;
   logic dir_down_reg, done_reg;
   logic [5:0] sel_sw_reg, state_sw_reg, sel_act_reg, state_act_reg;
   logic [2:0] sp_act_reg;
   logic [5:0] act, want;
   logic [2:0] raw;
   logic [5:0] pin_reg, oe_n_reg;
   logic irq_reg;
   // axi
   logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
   logic [31:0] aw_addr_reg, w_data_reg, rdata_reg, wmerged;
   logic [3:0] w_strb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic wr_fire, aw_take, w_take, ar_take;
   logic sp_start, sp_end, is_center, sync_point, ov_apply;

   function automatic logic reg_sel(input logic [31:0] a, input logic [7:0] ofs);
      reg_sel = (a[31:2] == {24'h0, ofs[7:2]});
   endfunction

   function automatic logic reg_mapped(input logic [31:0] a);
      reg_mapped = (a[31:8] == 24'h0) && (a[7:2] <= 6'(`PWO_OFS_STATUS >> 2));
   endfunction

   function automatic logic [31:0] reg_word(input logic [31:0] a);
      logic [31:0] v;
      v = 32'h0;
      if (reg_sel(a, `PWO_OFS_CTRL)) begin
         v[`PWO_CTRL_TB_EN] = tb_en_reg;
         v[`PWO_CTRL_MODE_LO +: 2] = mode_reg;
         v[`PWO_CTRL_OVERRIDE_SYNC_BIT] = override_sync_bit_reg;
         v[`PWO_CTRL_PMOD_LO +: 3] = pmod_reg;
         v[`PWO_CTRL_IRQ_EN] = irq_en_reg;
         v[`PWO_CTRL_PEN_LO +: 3] = pen_reg;
      end
      if (reg_sel(a, `PWO_OFS_PERIOD)) v[15:0] = period_reg;
      if (reg_sel(a, `PWO_OFS_DUTY0)) v[15:0] = duty_reg[0];
      if (reg_sel(a, `PWO_OFS_DUTY1)) v[15:0] = duty_reg[1];
      if (reg_sel(a, `PWO_OFS_DUTY2)) v[15:0] = duty_reg[2];
      if (reg_sel(a, `PWO_OFS_OVSEL)) v[5:0] = sel_sw_reg;
      if (reg_sel(a, `PWO_OFS_OVSTATE)) v[5:0] = state_sw_reg;
      if (reg_sel(a, `PWO_OFS_DEAD)) v[5:0] = dead_reg;
      if (reg_sel(a, `PWO_OFS_STATUS)) begin
         v[15:0] = count_reg;
         v[`PWO_STAT_DIR] = dir_down_reg;
         v[`PWO_STAT_DONE] = done_reg;
      end
      reg_word = v;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) m[8*b +: 8] = new_v[8*b +: 8];
      end
      merge = m;
   endfunction

   // axi4-lite slave: address and data latch independently, write applies when both are held
   assign aw_take = axi_req_in.awvalid && !aw_hold_reg && !bvalid_reg;
   assign w_take = axi_req_in.wvalid && !w_hold_reg && !bvalid_reg;
   assign ar_take = axi_req_in.arvalid && !rvalid_reg;
   assign wr_fire = aw_hold_reg && w_hold_reg;
   always_comb begin
      wmerged = merge(reg_word(aw_addr_reg), w_data_reg, w_strb_reg);
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `PWO_RESP_OKAY;
         aw_addr_reg <= 32'h0;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= axi_req_in.awaddr;
         end
         if (w_take) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= axi_req_in.wdata;
            w_strb_reg <= axi_req_in.wstrb;
         end
         if (wr_fire) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= reg_mapped(aw_addr_reg) ? `PWO_RESP_OKAY : `PWO_RESP_SLVERR;
         end else if (bvalid_reg && axi_req_in.bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= `PWO_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= reg_word(axi_req_in.araddr);
         rresp_reg <= reg_mapped(axi_req_in.araddr) ? `PWO_RESP_OKAY : `PWO_RESP_SLVERR;
      end else if (rvalid_reg && axi_req_in.rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   always_comb begin
      axi_rsp_out = '0;
      axi_rsp_out.awready = !aw_hold_reg && !bvalid_reg;
      axi_rsp_out.wready = !w_hold_reg && !bvalid_reg;
      axi_rsp_out.bvalid = bvalid_reg;
      axi_rsp_out.bresp = bresp_reg;
      axi_rsp_out.arready = !rvalid_reg;
      axi_rsp_out.rvalid = rvalid_reg;
      axi_rsp_out.rdata = rdata_reg;
      axi_rsp_out.rresp = rresp_reg;
   end

   // straps are fuse-like levels; sync flops are unreset so they settle while reset is held
   always_ff @(posedge clk_sys_in) begin
      strap_s1_reg <= {pin_reset_select_in, low_side_polarity_in, high_side_polarity_in};
      strap_s2_reg <= strap_s1_reg;
      strap_s3_reg <= strap_s2_reg;
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         strap_reg <= `PWO_RST_STRAP;
      end else begin
         strap_reg <= (strap_s2_reg & ~(strap_s2_reg ^ strap_s3_reg)) |
                      (strap_reg & (strap_s2_reg ^ strap_s3_reg));
      end
   end

   // control register; pin enables are loaded from the strap a few cycles after reset
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         tb_en_reg <= 1'b0;
         mode_reg <= PWO_MODE_FREE_EDGE;
         override_sync_bit_reg <= 1'b0;
         pmod_reg <= 3'h0;
         irq_en_reg <= 1'b0;
         pen_reg <= 3'h0;
         strap_cnt_reg <= 2'h0;
         cfg_done_reg <= 1'b0;
      end else begin
         if (!cfg_done_reg) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == 2'h3) begin
               cfg_done_reg <= 1'b1;
               pen_reg <= strap_reg[2] ? 3'h0 : `PWO_RST_PEN_STRAP;
            end
         end
         // hardware clears the enable at pulse end; a software write of 1 in that cycle wins
         if (sp_end) tb_en_reg <= 1'b0;
         if (wr_fire && reg_sel(aw_addr_reg, `PWO_OFS_CTRL)) begin
            tb_en_reg <= wmerged[`PWO_CTRL_TB_EN] | (tb_en_reg & !sp_end);
            if (!wmerged[`PWO_CTRL_TB_EN]) tb_en_reg <= 1'b0;
            mode_reg <= pwo_mode_e'(wmerged[`PWO_CTRL_MODE_LO +: 2]);
            override_sync_bit_reg <= wmerged[`PWO_CTRL_OVERRIDE_SYNC_BIT];
            pmod_reg <= wmerged[`PWO_CTRL_PMOD_LO +: 3];
            irq_en_reg <= wmerged[`PWO_CTRL_IRQ_EN];
            pen_reg <= wmerged[`PWO_CTRL_PEN_LO +: 3];
         end
      end
   end

   // period, duty and dead time change only by software writes, never by pulse end
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         period_reg <= `PWO_RST_PERIOD;
         duty_reg[0] <= `PWO_RST_DUTY;
         duty_reg[1] <= `PWO_RST_DUTY;
         duty_reg[2] <= `PWO_RST_DUTY;
         dead_reg <= `PWO_RST_DEAD;
      end else if (wr_fire) begin
         if (reg_sel(aw_addr_reg, `PWO_OFS_PERIOD)) period_reg <= wmerged[15:0];
         if (reg_sel(aw_addr_reg, `PWO_OFS_DUTY0)) duty_reg[0] <= wmerged[15:0];
         if (reg_sel(aw_addr_reg, `PWO_OFS_DUTY1)) duty_reg[1] <= wmerged[15:0];
         if (reg_sel(aw_addr_reg, `PWO_OFS_DUTY2)) duty_reg[2] <= wmerged[15:0];
         if (reg_sel(aw_addr_reg, `PWO_OFS_DEAD)) dead_reg <= wmerged[5:0];
      end
   end

   // time base; counts one step per clock, no prescaler here
   assign is_center = (mode_reg == PWO_MODE_CENTER) || (mode_reg == PWO_MODE_CENTER_DBL);
   assign sp_start = tb_en_reg && !tb_en_d_reg && (mode_reg == PWO_MODE_SINGLE);
   assign sp_end = tb_en_reg && (mode_reg == PWO_MODE_SINGLE) && (count_reg >= period_reg);

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         count_reg <= 16'h0;
         dir_down_reg <= 1'b0;
         tb_en_d_reg <= 1'b0;
      end else begin
         tb_en_d_reg <= tb_en_reg;
         if (tb_en_reg) begin
            if (is_center) begin
               if (!dir_down_reg) begin
                  if (count_reg >= period_reg) begin
                     dir_down_reg <= 1'b1;
                     if (count_reg != 16'h0) count_reg <= count_reg - 16'h1;
                  end else begin
                     count_reg <= count_reg + 16'h1;
                  end
               end else if (count_reg == 16'h0) begin
                  dir_down_reg <= 1'b0;
               end else begin
                  count_reg <= count_reg - 16'h1;
               end
            end else begin
               dir_down_reg <= 1'b0;
               count_reg <= (count_reg >= period_reg) ? 16'h0 : count_reg + 16'h1;
            end
         end
      end
   end

   // single-pulse state per pair; start beats the duty match in the same cycle
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sp_act_reg <= 3'h0;
      end else if (mode_reg != PWO_MODE_SINGLE || sp_end) begin
         sp_act_reg <= 3'h0;
      end else if (sp_start) begin
         sp_act_reg <= 3'h7;
      end else if (tb_en_reg) begin
         for (int p = 0; p < 3; p++) begin
            if (count_reg == duty_reg[p]) sp_act_reg[p] <= 1'b0;
         end
      end
   end

   // pulse-end event: sticky flag, write 1 to clear, a new end wins over the clear
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         done_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= sp_end && irq_en_reg;
         if (sp_end) begin
            done_reg <= 1'b1;
         end else if (wr_fire && reg_sel(aw_addr_reg, `PWO_OFS_STATUS) && wmerged[`PWO_STAT_DONE]) begin
            done_reg <= 1'b0;
         end
      end
   end

   // override registers: software copies and the copies that steer the pins
   assign sync_point = tb_en_reg && ((count_reg == 16'h0) || (is_center && count_reg == period_reg));
   assign ov_apply = !override_sync_bit_reg || sync_point;

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sel_sw_reg <= `PWO_RST_OVSEL;
         state_sw_reg <= `PWO_RST_OVSTATE;
      end else if (wr_fire) begin
         if (reg_sel(aw_addr_reg, `PWO_OFS_OVSEL)) sel_sw_reg <= wmerged[5:0];
         if (reg_sel(aw_addr_reg, `PWO_OFS_OVSTATE)) state_sw_reg <= wmerged[5:0];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sel_act_reg <= `PWO_RST_OVSEL;
         state_act_reg <= `PWO_RST_OVSTATE;
      end else if (ov_apply) begin
         sel_act_reg <= sel_sw_reg;
         state_act_reg <= state_sw_reg;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_pair
         logic cmd_reg;
         logic [5:0] dt_cnt_reg;
         logic cmd_next;

         // one duty generator per pair feeds both of its pins
         assign raw[g] = tb_en_reg && ((mode_reg == PWO_MODE_SINGLE) ? sp_act_reg[g]
                                       : (count_reg < duty_reg[g]));
         assign want[2*g+1] = sel_act_reg[2*g+1] ? raw[g] : state_act_reg[2*g+1];
         assign want[2*g] = sel_act_reg[2*g] ? raw[g] : state_act_reg[2*g];
         assign cmd_next = want[2*g+1];

         // dead time counts in system clocks and runs whether or not the odd pin is overridden
         always_ff @(posedge clk_sys_in) begin
            if (!rst_n_in) begin
               cmd_reg <= 1'b0;
               dt_cnt_reg <= 6'h0;
            end else if (cmd_next != cmd_reg) begin
               cmd_reg <= cmd_next;
               dt_cnt_reg <= dead_reg;
            end else if (dt_cnt_reg != 6'h0) begin
               dt_cnt_reg <= dt_cnt_reg - 6'h1;
            end
         end

         // complementary: even pin ignores its own state bit and follows the odd command
         assign act[2*g+1] = pmod_reg[g] ? want[2*g+1] : (cmd_reg && dt_cnt_reg == 6'h0);
         assign act[2*g] = pmod_reg[g] ? want[2*g] : (!cmd_reg && dt_cnt_reg == 6'h0);

         always_ff @(posedge clk_sys_in) begin
            if (!rst_n_in) begin
               pin_reg[2*g+1 -: 2] <= 2'h0;
               oe_n_reg[2*g+1 -: 2] <= 2'h3;
            end else begin
               pin_reg[2*g+1] <= act[2*g+1] ~^ strap_reg[0];
               pin_reg[2*g] <= act[2*g] ~^ strap_reg[1];
               oe_n_reg[2*g+1 -: 2] <= {2{!pen_reg[g]}};
            end
         end

         a_comp_exclusive: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
            !pmod_reg[g] |-> !(act[2*g+1] && act[2*g]))
            else $error("complementary pair drives both pins active");

         a_dead_gap: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
            (!pmod_reg[g] && cmd_next != cmd_reg && dead_reg != 6'h0) |=> (!act[2*g+1] && !act[2*g]))
            else $error("no dead time after complementary edge");

         a_pair_shared: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
            (pmod_reg[g] && sel_act_reg[2*g+1] && sel_act_reg[2*g]) |-> (act[2*g+1] == act[2*g]))
            else $error("independent pair pins differ under one duty generator");
      end
   endgenerate

   assign pwm_pin_out = pin_reg;
   assign pwm_pin_oe_n_out = oe_n_reg;
   assign period_irq_out = irq_reg;

   a_override_forced: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (pmod_reg[0] && !sel_act_reg[1]) |-> (act[1] == state_act_reg[1]))
      else $error("overridden pin does not follow its state bit");

   a_sp_start: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (sp_start && !sp_end) |=> (sp_act_reg == 3'h7))
      else $error("single pulse did not start active");

   a_sp_duty: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (mode_reg == PWO_MODE_SINGLE && tb_en_reg && !sp_start && count_reg == duty_reg[0]) |=> !sp_act_reg[0])
      else $error("single pulse did not end at duty match");

   a_sp_end: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (sp_end && !wr_fire) |=> (!tb_en_reg && count_reg == 16'h0 && sp_act_reg == 3'h0 && done_reg))
      else $error("single pulse end did not clear count, pins and enable");

   a_sp_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (sp_end && !wr_fire) |=> (period_reg == $past(period_reg) && duty_reg[0] == $past(duty_reg[0])))
      else $error("period or duty changed at pulse end");

   a_sync_wait: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (override_sync_bit_reg && !sync_point) |=> (sel_act_reg == $past(sel_act_reg)))
      else $error("override applied outside a sync point");

   a_edge_sync: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (override_sync_bit_reg && !is_center && tb_en_reg && count_reg == 16'h0) |=> (state_act_reg == $past(state_sw_reg)))
      else $error("override not applied at count zero");

   a_center_sync: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (override_sync_bit_reg && is_center && tb_en_reg && count_reg == period_reg) |=> (sel_act_reg == $past(sel_sw_reg)))
      else $error("override not applied at period match");

   a_nosync_apply: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      !override_sync_bit_reg |=> (sel_act_reg == $past(sel_sw_reg) && state_act_reg == $past(state_sw_reg)))
      else $error("override write not applied next cycle");

   a_reset_values: assert property (@(posedge clk_sys_in)
      $rose(rst_n_in) |-> (sel_sw_reg == 6'h3f && state_sw_reg == 6'h00 && sel_act_reg == 6'h3f))
      else $error("override registers wrong after reset");

   a_polarity_out: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      1'b1 |=> (pwm_pin_out[1] == ($past(act[1]) ~^ $past(strap_reg[0]))))
      else $error("high side pin polarity wrong");

   a_strap_enable: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (!cfg_done_reg && strap_cnt_reg == 2'h3 && !wr_fire) |=> (pen_reg == ($past(strap_reg[2]) ? 3'h0 : 3'h4)))
      else $error("pin enables not loaded from strap");

endmodule // pwo_core

//--- dv/pwo_power_stage.sv
`timescale 1ns/1ps
// power stage: a gate conducts only while its pin is driven at its active level
module pwo_power_stage (
   input wire logic [5:0] pin_in,
   input wire logic [5:0] oe_n_in,
   input wire logic high_pol_in,
   input wire logic low_pol_in,
   output logic [5:0] gate_on_out
);
   // a released pin is pulled off by the gate driver, so a stale level never conducts
   assign gate_on_out = ~oe_n_in & ~(pin_in ^ {3{high_pol_in, low_pol_in}});
endmodule // pwo_power_stage

//--- dv/pwm_override_single_pulse_bench.sv
`timescale 1ns/1ps
`include "pwo_map.svh"
module pwm_override_single_pulse_bench;
   import pwo_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic hp = 1'b1;
   logic lp = 1'b0;
   logic prs = 1'b0;
   pwo_axi_req_s req = '0;
   pwo_axi_rsp_s rsp;
   logic [5:0] pin, oe_n, gate;
   logic irq;
   logic [31:0] rdat;
   logic [1:0] resp;
   int err_total = 0;
   int num_checks = 0;
   int a0, a1, ai, b0, b1, bi;
   always #2 clk_sys_in = ~clk_sys_in;
   pwo_core dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .axi_req_in(req), .axi_rsp_out(rsp),
      .high_side_polarity_in(hp), .low_side_polarity_in(lp), .pin_reset_select_in(prs),
      .pwm_pin_out(pin), .pwm_pin_oe_n_out(oe_n), .period_irq_out(irq));
   pwo_power_stage stage (.pin_in(pin), .oe_n_in(oe_n), .high_pol_in(hp), .low_pol_in(lp),
      .gate_on_out(gate));
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask
   // ready is sampled at the falling edge so the rising edge acts on settled values
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      @(posedge clk_sys_in);
      req.awvalid <= 1'b1;
      req.awaddr <= {24'h000000, a};
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      do begin
         @(negedge clk_sys_in);
         aw = req.awvalid & rsp.awready;
         w = req.wvalid & rsp.wready;
         b = rsp.bvalid;
         resp = rsp.bresp;
         @(posedge clk_sys_in);
         if (aw) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
      end while (!b);
      req.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      logic ar, r;
      @(posedge clk_sys_in);
      req.arvalid <= 1'b1;
      req.araddr <= {24'h000000, a};
      req.rready <= 1'b1;
      do begin
         @(negedge clk_sys_in);
         ar = req.arvalid & rsp.arready;
         r = rsp.rvalid;
         rdat = rsp.rdata;
         resp = rsp.rresp;
         @(posedge clk_sys_in);
         if (ar) req.arvalid <= 1'b0;
      end while (!r);
      req.rready <= 1'b0;
   endtask
   task automatic ovr(input logic [31:0] c, input logic [5:0] s, input logic [5:0] e, input int n);
      wr(`PWO_OFS_CTRL, c);
      wr(`PWO_OFS_OVSEL, 32'h00000000);
      wr(`PWO_OFS_OVSTATE, {26'h0, s});
      repeat (n) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk({26'h0, gate}, {26'h0, e});
   endtask
   task automatic pulse(output int t0, output int t1, output int ti);
      t0 = 0;
      t1 = 0;
      ti = 0;
      wr(`PWO_OFS_CTRL, 32'h000007f3);
      for (int k = 1; k < 100; k++) begin
         @(negedge clk_sys_in);
         if (k == 3) chk({26'h0, gate}, 32'h0000003f);
         // pins are still inactive only for the first edge after the enable write
         if (k > 3 && t0 == 0 && gate[1:0] == 2'b00) t0 = k;
         if (k > 3 && t1 == 0 && gate[3:2] == 2'b00) t1 = k;
         if (irq === 1'b1) ti = k;
      end
      rd(`PWO_OFS_CTRL);
      chk(rdat, 32'h000007f2);
      chk({26'h0, gate}, 32'h00000000);
   endtask
   initial begin
      repeat (6) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      repeat (6) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk({26'h0, oe_n}, 32'h0000000f);
      rd(`PWO_OFS_OVSEL);
      chk(rdat, 32'h0000003f);
      rd(`PWO_OFS_OVSTATE);
      chk(rdat, 32'h00000000);
      wr(`PWO_OFS_OVSTATE, 32'h000000ff);
      chk({30'h0, resp}, {30'h0, `PWO_RESP_OKAY});
      rd(`PWO_OFS_OVSTATE);
      chk(rdat, 32'h0000003f);
      rd(8'hfc);
      chk({30'h0, resp}, {30'h0, `PWO_RESP_SLVERR});
      chk(rdat, 32'h00000000);
      ovr(32'h00000770, 6'h15, 6'h15, 4);
      ovr(32'h00000770, 6'h2a, 6'h2a, 4);
      ovr(32'h00000700, 6'h00, 6'h15, 4);
      ovr(32'h00000700, 6'h3f, 6'h2a, 4);
      // single pulse from a stopped count of zero: period 24, pair duties 8, 12 and beyond period
      wr(`PWO_OFS_PERIOD, 32'h00000018);
      wr(`PWO_OFS_DUTY0, 32'h00000008);
      wr(`PWO_OFS_DUTY1, 32'h0000000c);
      wr(`PWO_OFS_DUTY2, 32'h00000040);
      wr(`PWO_OFS_OVSEL, 32'h0000003f);
      pulse(a0, a1, ai);
      chk(32'(a1 - a0), 32'h00000004);
      chk({31'h0, ai - a0 >= 14 && ai - a0 <= 17}, 32'h00000001);
      pulse(b0, b1, bi);
      chk(32'(b0), 32'(a0));
      chk(32'(bi), 32'(ai));
      ovr(32'h00000708, 6'h3f, 6'h15, 8);
      ovr(32'h00000709, 6'h3f, 6'h2a, 300);
      ovr(32'h0000070d, 6'h00, 6'h15, 300);
      // odd command rises with 16 dead cycles: both pins stay off, then the odd pin follows
      wr(`PWO_OFS_DEAD, 32'h00000010);
      ovr(32'h00000700, 6'h3f, 6'h00, 4);
      ovr(32'h00000700, 6'h3f, 6'h2a, 24);
      // second reset with the other strap settings: pins released, inverted polarity
      @(posedge clk_sys_in);
      hp <= 1'b0;
      lp <= 1'b1;
      prs <= 1'b1;
      rst_n_in <= 1'b0;
      repeat (6) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      repeat (6) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk({26'h0, oe_n}, 32'h0000003f);
      ovr(32'h00000770, 6'h15, 6'h15, 4);
      chk({26'h0, pin}, 32'h0000003f);
      test_done();
   end
   // the whole sequence needs about a thousand cycles
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      err_total++;
      test_done();
   end
endmodule // pwm_override_single_pulse_bench
